// ==== serial_port_pkg.sv ====
// Register map, field positions and timing constants of the asynchronous serial port
package serial_port_pkg;

  // ==========================================================================
  // Register addresses (byte addresses of the plain register port)
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TX_HOLDING = 8'h19;
  localparam logic [7:0] ADDR_RX_DATA = 8'h1a;
  localparam logic [7:0] ADDR_INT_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIVISOR = 8'h99;

  // ==========================================================================
  // Receive status and control fields
  localparam int RS_PORT_EN = 7;
  localparam int RS_RX_NINE = 6;
  localparam int RS_SINGLE_RX = 5;
  localparam int RS_CONT_RX = 4;
  localparam int RS_ADDR_DET = 3;
  localparam int RS_FRAME_ERR = 2;
  localparam int RS_OVERRUN = 1;
  localparam int RS_RX_NINTH = 0;

  // Transmit status and control fields
  localparam int TS_CLK_SRC = 7;
  localparam int TS_TX_NINE = 6;
  localparam int TS_TX_EN = 5;
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPEED = 2;
  localparam int TS_SHIFT_EMPTY = 1;
  localparam int TS_TX_NINTH = 0;

  // Interrupt flag and enable fields
  localparam int IF_RX_READY = 5;
  localparam int IF_TX_EMPTY = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_TX_STATUS = 8'h02;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ==========================================================================
  // Baud and sampling constants
  localparam logic [5:0] PRESCALE_FAST = 6'h00; // x16 tick: every divisor period
  localparam logic [5:0] PRESCALE_SLOW = 6'h03; // x64: four divisor periods per tick
  localparam logic [3:0] TICKS_PER_BIT = 4'hf;  // Last of 16 ticks in a bit
  localparam logic [3:0] MID_BIT_TICK = 4'h7;   // Sample point inside a bit
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_START = 2'b01,
    LINK_DATA = 2'b10,
    LINK_STOP = 2'b11
  } link_state_t;

endpackage : serial_port_pkg

// ==== async_serial_port.sv ====
// Asynchronous serial port: baud generator, transmitter, receiver, two-entry FIFO
`timescale 1ns/1ps
module async_serial_port
  import serial_port_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutEnable,
  output logic rxInterrupt,
  output logic txInterrupt
);

  // ==========================================================================
  // Elaboration checks
  if (FIFO_DEPTH != 2) begin : g_depth_check
    $error("FIFO_DEPTH must be 2");
  end

  // ==========================================================================
  // Software-visible control registers
  logic [7:0] baudDivisor_r;
  logic [7:0] intEnables_r;
  logic portEnable_r, rxNine_r, singleRx_r, contRx_r, addrDetect_r;
  logic clkSrc_r, txNine_r, txEnable_r, syncMode_r, highSpeed_r, txNinth_r;
  logic txEmptyFlag_r;
  logic overrun_r;

  logic wrRxStatus, wrTxStatus, wrHolding, wrBaud, wrEnables, rdRxData;
  assign wrRxStatus = regWrite && (regAddr == ADDR_RX_STATUS);
  assign wrTxStatus = regWrite && (regAddr == ADDR_TX_STATUS);
  assign wrHolding = regWrite && (regAddr == ADDR_TX_HOLDING);
  assign wrBaud = regWrite && (regAddr == ADDR_BAUD_DIVISOR);
  assign wrEnables = regWrite && (regAddr == ADDR_INT_ENABLES);
  assign rdRxData = regRead && (regAddr == ADDR_RX_DATA);

  // Async operation needs port enabled and sync mode off
  logic asyncOn;
  assign asyncOn = portEnable_r && !syncMode_r;

  // Plain control bits: written straight from the bus
  always_ff @(posedge core_clk) begin
    if (reset) begin
      baudDivisor_r <= RST_ZERO;
      intEnables_r <= RST_ZERO;
      {portEnable_r, rxNine_r, singleRx_r, contRx_r, addrDetect_r} <= 5'h00;
      {clkSrc_r, txNine_r, txEnable_r, syncMode_r, highSpeed_r, txNinth_r} <= 6'h00;
    end else begin
      if (wrBaud) baudDivisor_r <= regWrData;
      if (wrEnables) intEnables_r <= regWrData;
      if (wrRxStatus) begin
        portEnable_r <= regWrData[RS_PORT_EN];
        rxNine_r <= regWrData[RS_RX_NINE];
        singleRx_r <= regWrData[RS_SINGLE_RX];
        contRx_r <= regWrData[RS_CONT_RX];
        addrDetect_r <= regWrData[RS_ADDR_DET];
      end
      if (wrTxStatus) begin
        clkSrc_r <= regWrData[TS_CLK_SRC];
        txNine_r <= regWrData[TS_TX_NINE];
        txEnable_r <= regWrData[TS_TX_EN];
        syncMode_r <= regWrData[TS_SYNC];
        highSpeed_r <= regWrData[TS_HIGH_SPEED];
        txNinth_r <= regWrData[TS_TX_NINTH];
      end
    end
  end

  // ==========================================================================
  // Baud generator: divisor+1 clocks per period, prescaled for x64
  logic [7:0] baudCnt_r;
  logic [5:0] preCnt_r;
  logic sampleTick;
  logic baudRun;
  assign baudRun = txEnable_r || contRx_r;
  // A prescale count already past the limit after a speed change in mid-run ends the
  // period at once, instead of wrapping round the whole counter first
  assign sampleTick = baudRun && (baudCnt_r == 8'h00)
                      && (preCnt_r >= (highSpeed_r ? PRESCALE_FAST : PRESCALE_SLOW));

  // Held in reset while both directions are off
  always_ff @(posedge core_clk) begin
    if (reset || !baudRun) begin
      baudCnt_r <= RST_ZERO;
      preCnt_r <= 6'h00;
    end else if (baudCnt_r == 8'h00) begin
      // Reload on expiry: one period is the divisor plus one clocks
      baudCnt_r <= baudDivisor_r;
      preCnt_r <= sampleTick ? 6'h00 : preCnt_r + 6'h01;
    end else begin
      baudCnt_r <= baudCnt_r - 8'h01;
    end
  end

  // ==========================================================================
  // Transmitter
  // Holding register and full flag decouple software from the shifter
  logic [7:0] txHolding_r;
  logic txHoldFull_r;
  logic [8:0] txShift_r;
  logic [3:0] txTick_r, txBits_r;
  link_state_t txState_r;
  logic txLoad;
  // Shifter takes a byte only between frames, so a stop bit is never cut short
  assign txLoad = txEnable_r && asyncOn && txHoldFull_r && (txState_r == LINK_IDLE);

  // Holding register and its empty flag; the write wins over a same-cycle load
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txHolding_r <= RST_ZERO;
      txHoldFull_r <= 1'b0;
      txEmptyFlag_r <= 1'b0;
    end else begin
      if (wrHolding) txHolding_r <= regWrData;
      if (wrHolding) begin
        txHoldFull_r <= 1'b1;
        txEmptyFlag_r <= 1'b0;
      end else if (txLoad) begin
        txHoldFull_r <= 1'b0;
        txEmptyFlag_r <= 1'b1;
      end else if (wrTxStatus && regWrData[TS_TX_EN] && !txHoldFull_r) begin
        txEmptyFlag_r <= 1'b1;
      end
    end
  end

  // Transmit shifter; clearing transmit enable aborts and resets it
  always_ff @(posedge core_clk) begin
    if (reset || !txEnable_r || !asyncOn) begin
      txState_r <= LINK_IDLE;
      txShift_r <= 9'h000;
      txTick_r <= 4'h0;
      txBits_r <= 4'h0;
      serialOutPin <= 1'b1;
    end else begin
      unique case (txState_r)
        LINK_IDLE: begin
          serialOutPin <= 1'b1;
          if (txLoad) begin
            txShift_r <= {txNinth_r, txHolding_r};
            txState_r <= LINK_START;
            txTick_r <= 4'h0;
          end
        end
        LINK_START: begin
          serialOutPin <= 1'b0;
          if (sampleTick) begin
            txTick_r <= txTick_r + 4'h1;
            if (txTick_r == TICKS_PER_BIT) begin
              txState_r <= LINK_DATA;
              txBits_r <= 4'h0;
            end
          end
        end
        LINK_DATA: begin
          serialOutPin <= txShift_r[0];
          if (sampleTick) begin
            txTick_r <= txTick_r + 4'h1;
            if (txTick_r == TICKS_PER_BIT) begin
              txShift_r <= {1'b0, txShift_r[8:1]};
              txBits_r <= txBits_r + 4'h1;
              if (txBits_r == (txNine_r ? BITS_NINE : BITS_EIGHT) - 4'h1) begin
                txState_r <= LINK_STOP;
              end
            end
          end
        end
        LINK_STOP: begin
          serialOutPin <= 1'b1;
          if (sampleTick) begin
            txTick_r <= txTick_r + 4'h1;
            if (txTick_r == TICKS_PER_BIT) txState_r <= LINK_IDLE;
          end
        end
      endcase
    end
  end

  // Pin driven only while the async transmitter is enabled
  always_ff @(posedge core_clk) begin
    if (reset) serialOutEnable <= 1'b0;
    else serialOutEnable <= txEnable_r && asyncOn;
  end

  // ==========================================================================
  // Receive pin synchroniser
  // Both flops reset to the idle level, so no false start follows reset
  logic rxMeta_r, rxSync_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= serialInPin;
      rxSync_r <= rxMeta_r;
    end
  end

  // ==========================================================================
  // Receiver: oversampled recovery into the receive shift register
  logic rxRun;
  assign rxRun = asyncOn && contRx_r;
  link_state_t rxState_r;
  logic [3:0] rxTick_r, rxBits_r;
  logic [8:0] rxShift_r;
  logic rxDone, rxStopBit;
  // End of character: middle of the stop bit, where the framing check is made
  assign rxDone = (rxState_r == LINK_STOP) && sampleTick && (rxTick_r == MID_BIT_TICK);
  assign rxStopBit = rxSync_r;

  // Mid-bit sampling on the x16 tick; a short start pulse is rejected as noise
  always_ff @(posedge core_clk) begin
    if (reset || !rxRun) begin
      rxState_r <= LINK_IDLE;
      rxTick_r <= 4'h0;
      rxBits_r <= 4'h0;
      rxShift_r <= 9'h000;
    end else if (sampleTick) begin
      rxTick_r <= rxTick_r + 4'h1;
      unique case (rxState_r)
        LINK_IDLE: begin
          rxTick_r <= 4'h0;
          if (!rxSync_r) rxState_r <= LINK_START;
        end
        LINK_START: begin
          if (rxTick_r == MID_BIT_TICK) begin
            if (rxSync_r) rxState_r <= LINK_IDLE;
          end else if (rxTick_r == TICKS_PER_BIT) begin
            rxState_r <= LINK_DATA;
            rxBits_r <= 4'h0;
          end
        end
        LINK_DATA: begin
          if (rxTick_r == MID_BIT_TICK) begin
            // Nine-bit mode shifts into bit 8; eight-bit mode keeps bit 8 clear
            rxShift_r <= rxNine_r ? {rxSync_r, rxShift_r[8:1]}
                                  : {1'b0, rxSync_r, rxShift_r[7:1]};
            rxBits_r <= rxBits_r + 4'h1;
          end else if (rxTick_r == TICKS_PER_BIT
                       && rxBits_r == (rxNine_r ? BITS_NINE : BITS_EIGHT)) begin
            rxState_r <= LINK_STOP;
          end
        end
        LINK_STOP: begin
          if (rxTick_r == MID_BIT_TICK) rxState_r <= LINK_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Two-entry receive FIFO with per-entry framing and ninth bits
  logic [9:0] fifoMem_r [FIFO_DEPTH];
  logic [1:0] fifoCount_r;
  logic fifoHead_r;
  logic acceptChar, pushChar, popChar;
  logic fifoTail;
  // Fill levels; the count is one bit wider than the slot index
  localparam logic [1:0] FIFO_EMPTY = 2'd0;
  localparam logic [1:0] FIFO_FULL = 2'(FIFO_DEPTH);
  // In nine-bit mode, address detect keeps only characters whose ninth bit is set
  assign acceptChar = !(rxNine_r && addrDetect_r && !rxShift_r[8]);
  // A read of an empty store pops nothing and returns zero
  assign popChar = rdRxData && (fifoCount_r != FIFO_EMPTY);
  assign pushChar = rxDone && acceptChar && !overrun_r
                    && (fifoCount_r != FIFO_FULL || popChar);
  // Free slot lies count places past the head; a same-cycle pop does not move it
  assign fifoTail = fifoHead_r ^ fifoCount_r[0];

  function automatic logic nextSlot(input logic idx);
    nextSlot = ~idx;
  endfunction : nextSlot

  // Entry layout: framing error, ninth bit, data byte
  always_ff @(posedge core_clk) begin
    if (reset || !rxRun) begin
      fifoCount_r <= 2'd0;
      fifoHead_r <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) fifoMem_r[i] <= 10'h000;
    end else begin
      if (pushChar) begin
        fifoMem_r[fifoTail] <= {~rxStopBit, rxShift_r};
      end
      if (popChar) fifoHead_r <= nextSlot(fifoHead_r);
      // Net change, so a push and a pop in one cycle leave the count as it is
      fifoCount_r <= fifoCount_r + {1'b0, pushChar} - {1'b0, popChar};
    end
  end

  // Overrun: only a drop of continuous enable clears it
  always_ff @(posedge core_clk) begin
    if (reset || !contRx_r) overrun_r <= 1'b0;
    // A pop in the same cycle frees a slot, so that character is kept, not lost
    else if (rxDone && acceptChar && fifoCount_r == FIFO_FULL && !popChar) overrun_r <= 1'b1;
  end

  logic rxReady;
  // Ready is simply not-empty, so it drops on the read that drains the store
  assign rxReady = (fifoCount_r != FIFO_EMPTY);
  // Status bits of the head entry stand until the data read moves the head
  logic [9:0] headEntry;
  assign headEntry = fifoMem_r[fifoHead_r];

  // ==========================================================================
  // Interrupt outputs and read data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rxInterrupt <= 1'b0;
      txInterrupt <= 1'b0;
    end else begin
      rxInterrupt <= rxReady && intEnables_r[IF_RX_READY];
      txInterrupt <= txEmptyFlag_r && intEnables_r[IF_TX_EMPTY];
    end
  end

  // Read data valid in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regRdData <= RST_ZERO;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_INT_FLAGS: regRdData <= 8'({rxReady, txEmptyFlag_r}) << IF_TX_EMPTY;
        ADDR_RX_STATUS: regRdData <= {portEnable_r, rxNine_r, singleRx_r, contRx_r,
                                      addrDetect_r, headEntry[9] & rxReady, overrun_r,
                                      headEntry[8] & rxReady};
        ADDR_TX_HOLDING: regRdData <= txHolding_r;
        ADDR_RX_DATA: regRdData <= rxReady ? headEntry[7:0] : RST_ZERO;
        ADDR_INT_ENABLES: regRdData <= intEnables_r;
        ADDR_TX_STATUS: regRdData <= {clkSrc_r, txNine_r, txEnable_r, syncMode_r, 1'b0,
                                      highSpeed_r, txState_r == LINK_IDLE,
                                      txNinth_r};
        ADDR_BAUD_DIVISOR: regRdData <= baudDivisor_r;
        default: regRdData <= RST_ZERO;
      endcase
    end else begin
      regRdData <= RST_ZERO;
    end
  end

endmodule : async_serial_port

// ==== async_serial_port_sva.sv ====
// Checker of the serial port's register read port and transmit line
`timescale 1ns/1ps
module async_serial_port_sva
  import serial_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic serialInPin,
  input wire logic serialOutPin,
  input wire logic serialOutEnable,
  input wire logic rxInterrupt,
  input wire logic txInterrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Register port
  a_read_idle: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (regRead && regAddr == 8'h55 |=> regRdData == 8'h00)
    else $error("unmapped read returned data");
  a_flags_reserved: assert property (regRead && regAddr == ADDR_INT_FLAGS |=>
    (regRdData & 8'hcf) == 8'h00) else $error("unused flag bits read as one");
  a_txstat_gap: assert property (regRead && regAddr == ADDR_TX_STATUS |=>
    regRdData[3] == 1'b0) else $error("unused transmit status bit read as one");

  // ==========================================================================
  // Interrupt masking: a cleared enable must silence the line within two edges
  a_rx_masked: assert property (regWrite && regAddr == ADDR_INT_ENABLES &&
    !regWrData[IF_RX_READY] |=> ##1 !rxInterrupt) else $error("receive interrupt not masked");
  a_tx_masked: assert property (regWrite && regAddr == ADDR_INT_ENABLES &&
    !regWrData[IF_TX_EMPTY] |=> ##1 !txInterrupt) else $error("transmit interrupt not masked");

  // ==========================================================================
  // Line levels hold for at least eight clocks, so never a short glitch
  a_low_hold: assert property ($fell(serialOutPin) |-> !serialOutPin [*8])
    else $error("transmit line low for too short a time");
  a_high_hold: assert property ($rose(serialOutPin) |-> serialOutPin [*8])
    else $error("transmit line high for too short a time");

  c_rx_int: cover property ($rose(rxInterrupt));
  c_tx_int: cover property ($rose(txInterrupt));
  c_frame: cover property ($fell(serialOutPin));
endmodule : async_serial_port_sva

bind async_serial_port async_serial_port_sva chk_u (.core_clk(core_clk), .reset(reset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
  .serialOutEnable(serialOutEnable), .rxInterrupt(rxInterrupt), .txInterrupt(txInterrupt));

// ==== serial_node.sv ====
// Remote serial node: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
module serial_node (
  input wire logic core_clk,
  output logic lineOut,
  input wire logic lineIn
);
  int bitClks = 16;
  logic [8:0] gotFrame = 9'h000;
  int gotCount = 0;

  // ==========================================================================
  // Sender; the line idles high as a pulled-up wire would
  initial lineOut = 1'b1;
  task automatic send(input logic [8:0] v, input int nb, input logic stopBit);
    lineOut <= 1'b0;
    repeat (bitClks) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      lineOut <= v[i];
      repeat (bitClks) @(posedge core_clk);
    end
    lineOut <= stopBit;
    repeat (bitClks) @(posedge core_clk);
    lineOut <= 1'b1;
    repeat (bitClks) @(posedge core_clk);
  endtask : send

  // ==========================================================================
  // Receiver; nine samples so an eight-bit frame shows its stop bit as bit 8
  always begin
    @(negedge lineIn);
    repeat (bitClks / 2) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bitClks) @(posedge core_clk);
      gotFrame[i] = lineIn;
    end
    gotCount++;
  end
endmodule : serial_node

// ==== async_serial_port_test.sv ====
// Register-level testbench of the asynchronous serial port
`timescale 1ns/1ps
module async_serial_port_test;
  import serial_port_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic serialInPin;
  logic serialOutPin;
  logic serialOutEnable;
  logic rxInterrupt;
  logic txInterrupt;
  int failures = 0;
  int num_checks = 0;
  logic [7:0] mapAddr [8] = '{ADDR_INT_FLAGS, ADDR_RX_STATUS, ADDR_TX_HOLDING, ADDR_RX_DATA,
    ADDR_INT_ENABLES, ADDR_TX_STATUS, ADDR_BAUD_DIVISOR, 8'h55};

  always #20 core_clk = ~core_clk;

  async_serial_port dut_u (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .serialInPin(serialInPin), .serialOutPin(serialOutPin),
    .serialOutEnable(serialOutEnable), .rxInterrupt(rxInterrupt), .txInterrupt(txInterrupt));
  serial_node part_u (.core_clk(core_clk), .lineOut(serialInPin), .lineIn(serialOutPin));

  // ==========================================================================
  // Access tasks
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    check({1'b0, regRdData & mask}, {1'b0, exp});
  endtask : rd

  // Waits for the node to decode a frame, then lets its tail finish
  task automatic waitTx(input logic [8:0] exp);
    int startCount;
    startCount = part_u.gotCount;
    for (int k = 0; k < 2000 && part_u.gotCount == startCount; k++) @(posedge core_clk);
    check({8'h00, part_u.gotCount != startCount}, 9'h001);
    check(part_u.gotFrame, exp);
    repeat (2 * part_u.bitClks) @(posedge core_clk);
  endtask : waitTx

  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Watchdog; the whole sequence needs well under a third of this span
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(mapAddr[i], (mapAddr[i] == ADDR_TX_STATUS) ? RST_TX_STATUS : RST_ZERO, 8'hff);
    end
    // Transmit at x16, then nine-bit, then x64
    wr(ADDR_BAUD_DIVISOR, 8'h00);
    wr(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_INT_ENABLES, 8'h30);
    wr(ADDR_TX_STATUS, 8'h24);
    rd(ADDR_INT_FLAGS, 8'h10, 8'h10);
    check({8'h00, serialOutEnable}, 9'h001);
    wr(ADDR_TX_HOLDING, 8'ha5);
    rd(ADDR_TX_STATUS, 8'h00, 8'h02);
    check({8'h00, txInterrupt}, 9'h001);
    waitTx(9'h1a5);
    rd(ADDR_TX_STATUS, 8'h02, 8'h02);
    wr(ADDR_TX_STATUS, 8'h64);
    wr(ADDR_TX_HOLDING, 8'h3c);
    waitTx(9'h03c);
    part_u.bitClks = 64;
    wr(ADDR_TX_STATUS, 8'h20);
    wr(ADDR_TX_HOLDING, 8'h96);
    waitTx(9'h196);
    part_u.bitClks = 16;
    // Back to x16 for reception; the transmitter is switched off and releases its pin
    wr(ADDR_TX_STATUS, 8'h04);
    @(posedge core_clk);
    #1;
    check({8'h00, serialOutEnable}, 9'h000);
    // Two-deep FIFO, overrun and recovery
    wr(ADDR_RX_STATUS, 8'h90);
    part_u.send(9'h03c, 8, 1'b1);
    part_u.send(9'h05a, 8, 1'b1);
    wr(ADDR_INT_FLAGS, 8'h00);
    rd(ADDR_INT_FLAGS, 8'h20, 8'h20);
    check({8'h00, rxInterrupt}, 9'h001);
    wr(ADDR_INT_ENABLES, 8'h00);
    @(posedge core_clk);
    #1;
    check({7'h00, rxInterrupt, txInterrupt}, 9'h000);
    part_u.send(9'h0c3, 8, 1'b1);
    rd(ADDR_RX_STATUS, 8'h02, 8'h02);
    rd(ADDR_RX_DATA, 8'h3c, 8'hff);
    rd(ADDR_RX_DATA, 8'h5a, 8'hff);
    rd(ADDR_INT_FLAGS, 8'h00, 8'h20);
    part_u.send(9'h011, 8, 1'b1);
    rd(ADDR_INT_FLAGS, 8'h00, 8'h20);
    wr(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_RX_STATUS, 8'h90);
    rd(ADDR_RX_STATUS, 8'h00, 8'h02);
    // Nine-bit reception with per-entry framing error and ninth bit
    wr(ADDR_RX_STATUS, 8'hd0);
    part_u.send(9'h1e7, 9, 1'b0);
    part_u.send(9'h024, 9, 1'b1);
    rd(ADDR_RX_STATUS, 8'h05, 8'h07);
    rd(ADDR_RX_DATA, 8'he7, 8'hff);
    rd(ADDR_RX_STATUS, 8'h00, 8'h07);
    rd(ADDR_RX_DATA, 8'h24, 8'hff);
    // Address detect: data dropped, address kept, then all kept
    wr(ADDR_RX_STATUS, 8'hd8);
    part_u.send(9'h055, 9, 1'b1);
    rd(ADDR_INT_FLAGS, 8'h00, 8'h20);
    part_u.send(9'h142, 9, 1'b1);
    rd(ADDR_RX_STATUS, 8'h01, 8'h01);
    rd(ADDR_RX_DATA, 8'h42, 8'hff);
    wr(ADDR_RX_STATUS, 8'hd0);
    part_u.send(9'h066, 9, 1'b1);
    rd(ADDR_RX_DATA, 8'h66, 8'hff);
    // Reception off with continuous enable clear
    wr(ADDR_RX_STATUS, 8'hc0);
    part_u.send(9'h077, 9, 1'b1);
    rd(ADDR_INT_FLAGS, 8'h00, 8'h20);
    report_and_stop();
  end
endmodule : async_serial_port_test
